/* core/dlp_line_proc.sv */
// Purpose: Line trigger, row combine, colour align and interpolation
// Assumes: Sensor pixels arrive column by column, both rows together
// Notes: Registers over AXI4-Lite, single clock, no interrupts
`timescale 1ns/1ns
// What this block does
// - Colour: row one red/blue, row two green
// - Realign red/blue row against green row
// - Alignment scale resets to one
// - Alignment scale accepts zero to 1.5
// - RGB8 output interpolates missing red/blue
// - Edge columns use their single neighbour
// - Basic: mean of left and right
// - Enhanced: neighbour mean plus green variation
// - Combine modes limited by sensor model
// - Single row default, one row per trigger
// - Summing mode outputs per-pixel row sum
// - Averaging mode outputs per-pixel row mean
// - Dual exposure merge into one row
// - Both rows out, row one first
// - 8k single mode gives 4k line
// - Super resolution interleaves both offset rows
// - Triggers only while acquisition active
// - Free run from internal line rate timer
// - External trigger passes programmable debounce
// - Frames of programmed line count
// - Hold one pending trigger while busy
// - Frame rate is line rate over height
module dlp_line_proc (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_trig_in,
	output logic line_sync_trigger,
	input wire logic in_valid,
	input wire logic [dlp_pkg::PIX_W-1:0] in_row1,
	input wire logic [dlp_pkg::PIX_W-1:0] in_row2,
	input wire logic in_last,
	output logic in_ready,
	output logic out_valid,
	output logic [23:0] out_data,
	output logic out_last,
	output logic out_frame_end
);
	import dlp_pkg::*;

	function automatic logic [11:0] sat12(input logic [12:0] v);
		sat12 = v[12] ? PIX_MAX : v[11:0];
	endfunction

	function automatic logic [11:0] clamp12(input logic signed [24:0] v);
		if (v < 0)
			clamp12 = 12'h000;
		else if (v > 25'sd4095)
			clamp12 = PIX_MAX;
		else
			clamp12 = v[11:0];
	endfunction

	function automatic logic legal_mode(input logic [1:0] mdl,
		input logic [2:0] m);
		case (mdl)
			MODEL_2K: legal_mode = (m <= MODE_AVG);
			MODEL_4K: legal_mode = (m <= MODE_BOTH);
			MODEL_8K: legal_mode = (m == MODE_SINGLE) || (m == MODE_SR);
			default: legal_mode = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			wmerge[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
	endfunction

	// ***********************************************
	// Register bus
	// ***********************************************
	logic [6:0] ctrl_q;
	logic [2:0] mode_q;
	logic [8:0] scale_q;
	logic [31:0] rate_q, expo_q, fps_q;
	logic [15:0] height_q, deb_q, line_cnt_q;
	logic aw_ok_q, w_ok_q, pend_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, wr_val, rd_val;
	logic [3:0] wstrb_q;
	logic rd_err;
	dlp_state_t st_q;
	wire acq = ctrl_q[CTRL_ACQ];
	wire [1:0] model = ctrl_q[CTRL_MODEL +: 2];
	wire do_wr = aw_ok_q && w_ok_q && !s_axi_bvalid;

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			aw_ok_q <= 1'b0;
			w_ok_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else
		begin
			s_axi_awready <= !aw_ok_q && !s_axi_awready;
			s_axi_wready <= !w_ok_q && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_ok_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_ok_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q[1:0] == 2'h0 &&
					awaddr_q <= OFS_DEBOUNCE) ? 2'h0 : 2'h2;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_ok_q <= 1'b0;
				w_ok_q <= 1'b0;
			end
		end

	always_comb
	begin
		wr_val = 32'h0;
		case (awaddr_q)
			OFS_CTRL: wr_val = wmerge({25'h0, ctrl_q}, wdata_q, wstrb_q);
			OFS_MODE: wr_val = wmerge({29'h0, mode_q}, wdata_q, wstrb_q);
			OFS_SCALE: wr_val = wmerge({23'h0, scale_q}, wdata_q, wstrb_q);
			OFS_RATE: wr_val = wmerge(rate_q, wdata_q, wstrb_q);
			OFS_EXPO: wr_val = wmerge(expo_q, wdata_q, wstrb_q);
			OFS_HEIGHT: wr_val = wmerge({16'h0, height_q}, wdata_q, wstrb_q);
			OFS_DEBOUNCE: wr_val = wmerge({16'h0, deb_q}, wdata_q, wstrb_q);
			default: wr_val = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			ctrl_q <= CTRL_RST;
			mode_q <= MODE_SINGLE;
			scale_q <= SCALE_ONE;
			rate_q <= RATE_RST;
			expo_q <= EXPO_RST;
			height_q <= HEIGHT_RST;
			deb_q <= DEBOUNCE_RST;
		end
		else if (do_wr)
			case (awaddr_q)
				OFS_CTRL:
				begin
					ctrl_q <= wr_val[6:0];
					// Model change keeps the mode legal for the new sensor
					if (!legal_mode(wr_val[CTRL_MODEL +: 2], mode_q))
						mode_q <= MODE_SINGLE;
				end
				OFS_MODE:
					if (legal_mode(model, wr_val[2:0]))
						mode_q <= wr_val[2:0];
				OFS_SCALE:
					scale_q <= (wr_val[31:0] > {23'h0, SCALE_MAX}) ?
						SCALE_MAX : wr_val[8:0];
				OFS_RATE: rate_q <= wr_val;
				OFS_EXPO: expo_q <= wr_val;
				OFS_HEIGHT: height_q <= (wr_val[15:0] == 16'h0) ?
					16'h0001 : wr_val[15:0];
				OFS_DEBOUNCE: deb_q <= wr_val[15:0];
				default: ctrl_q <= ctrl_q;
			endcase

	always_comb
	begin
		rd_err = 1'b0;
		case (s_axi_araddr)
			OFS_CTRL: rd_val = {25'h0, ctrl_q};
			OFS_MODE: rd_val = {29'h0, mode_q};
			OFS_SCALE: rd_val = {23'h0, scale_q};
			OFS_RATE: rd_val = rate_q;
			OFS_EXPO: rd_val = expo_q;
			OFS_HEIGHT: rd_val = {16'h0, height_q};
			OFS_DEBOUNCE: rd_val = {16'h0, deb_q};
			OFS_STATUS: rd_val = {10'h0, !st_q[0], pend_q, st_q, line_cnt_q};
			OFS_FPS: rd_val = fps_q;
			default:
			begin
				rd_val = 32'h0;
				rd_err = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
			end
			else if (s_axi_rready && s_axi_rvalid)
				s_axi_rvalid <= 1'b0;
		end

	// ***********************************************
	// Line trigger generation
	// ***********************************************
	logic [31:0] acc_q, since_q, rem_q, quo_q;
	logic [15:0] deb_cnt_q;
	logic [5:0] div_n_q;
	logic filt_q, filt_prev_q;
	wire [32:0] acc_sum = {1'b0, acc_q} + {1'b0, rate_q};
	wire tick = (acc_sum >= {1'b0, CLK_HZ});
	wire deb_rise = filt_q && !filt_prev_q;
	wire trig_event = acq && (ctrl_q[CTRL_TRIG] ? deb_rise : tick);
	// Free run rate is capped by exposure; external sources are not
	wire expo_ok = ctrl_q[CTRL_TRIG] || (since_q >= expo_q);
	wire issue = acq && (st_q == ST_IDLE) && (trig_event || pend_q) &&
		expo_ok;

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			acc_q <= 32'h0;
		else
			acc_q <= tick ? 32'(acc_sum - {1'b0, CLK_HZ}) : acc_sum[31:0];

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			since_q <= 32'h0;
		else if (issue)
			since_q <= 32'h1;
		else if (since_q != 32'hffff_ffff)
			since_q <= since_q + 32'h1;

	// Input must hold its new level for the whole period to count
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			deb_cnt_q <= 16'h0;
			filt_q <= 1'b0;
			filt_prev_q <= 1'b0;
		end
		else
		begin
			filt_prev_q <= filt_q;
			if (ext_trig_in == filt_q)
				deb_cnt_q <= 16'h0;
			else if (deb_cnt_q >= deb_q)
			begin
				filt_q <= ext_trig_in;
				deb_cnt_q <= 16'h0;
			end
			else
				deb_cnt_q <= deb_cnt_q + 16'h1;
		end

	// Set wins over the clear of a serviced trigger
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			pend_q <= 1'b0;
		else if (!acq)
			pend_q <= 1'b0;
		else if (trig_event && !(issue && !pend_q))
			pend_q <= 1'b1;
		else if (issue)
			pend_q <= 1'b0;

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			line_sync_trigger <= 1'b0;
		else
			line_sync_trigger <= issue;

	// Serial divider refreshes the frame rate every 33 cycles
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			div_n_q <= 6'h0;
			rem_q <= 32'h0;
			quo_q <= 32'h0;
			fps_q <= 32'h0;
		end
		else if (div_n_q == 6'h20)
		begin
			fps_q <= quo_q;
			div_n_q <= 6'h0;
			rem_q <= 32'h0;
			quo_q <= rate_q;
		end
		else
		begin
			div_n_q <= div_n_q + 6'h1;
			if ({rem_q[30:0], quo_q[31]} >= {16'h0, height_q})
			begin
				rem_q <= {rem_q[30:0], quo_q[31]} - {16'h0, height_q};
				quo_q <= {quo_q[30:0], 1'b1};
			end
			else
			begin
				rem_q <= {rem_q[30:0], quo_q[31]};
				quo_q <= {quo_q[30:0], 1'b0};
			end
		end

	// ***********************************************
	// Row combine and colour alignment
	// ***********************************************
	logic [11:0] line_mem [0:LINE_MAX-1];
	logic [11:0] col_q, last_col_q, sr_hold_q, mono_v, rb_al;
	logic sr_ph_q;
	wire color = ctrl_q[CTRL_COLOR];
	wire rgb = color && ctrl_q[CTRL_RGB8];
	wire take = in_valid && in_ready;
	wire [12:0] sum13 = {1'b0, in_row1} + {1'b0, in_row2};
	wire [11:0] sum_sat = sat12(sum13);
	wire [12:0] hdr_sh = 13'({1'b0, in_row1} << HDR_SHIFT);
	wire [11:0] prev_rb = line_mem[col_q];
	wire signed [12:0] rb_diff = $signed({1'b0, prev_rb}) -
		$signed({1'b0, in_row1});
	wire signed [24:0] rb_mix = 25'($signed({1'b0, in_row1}) +
		((rb_diff * $signed({1'b0, scale_q})) >>> 8));

	// Red/blue row leads; blend toward last line by the spacing scale
	always_comb
		rb_al = clamp12(rb_mix);

	always_comb
	begin
		mono_v = in_row1;
		if (color)
			mono_v = in_row2;
		else
			case (mode_q)
				MODE_SUM: mono_v = sum_sat;
				MODE_AVG: mono_v = sum13[12:1];
				// Long row until it nears clipping, then scaled short row
				MODE_HDR: mono_v = (in_row2 < HDR_KNEE) ? in_row2 :
					sat12(hdr_sh);
				default: mono_v = in_row1;
			endcase
	end

	always_ff @(posedge clk)
		if (take && color)
			line_mem[col_q] <= in_row1;
		else if (take && mode_q == MODE_BOTH)
			line_mem[col_q] <= in_row2;

	// ***********************************************
	// Interpolation window
	// ***********************************************
	logic [11:0] p1_rb_q, p1_g_q, p2_rb_q, p2_g_q, mis_v;
	logic p1_v_q, p2_v_q, p1_odd_q;
	wire flush = (st_q == ST_FLUSH);
	wire have_r = !flush;
	wire [11:0] l_rb = p2_v_q ? p2_rb_q : rb_al;
	wire [11:0] l_g = p2_v_q ? p2_g_q : in_row2;
	wire [11:0] r_rb = have_r ? rb_al : p2_rb_q;
	wire [11:0] r_g = have_r ? in_row2 : p2_g_q;
	wire [12:0] nb_sum = {1'b0, l_rb} + {1'b0, r_rb};
	wire [12:0] ng_sum = {1'b0, l_g} + {1'b0, r_g};
	wire signed [24:0] enh = 25'($signed({1'b0, nb_sum[12:1]}) +
		$signed({1'b0, p1_g_q}) - $signed({1'b0, ng_sum[12:1]}));

	always_comb
		if (ctrl_q[CTRL_ENH])
			mis_v = clamp12(enh);
		else
			mis_v = nb_sum[12:1];

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			p1_v_q <= 1'b0;
			p2_v_q <= 1'b0;
			p1_odd_q <= 1'b0;
			p1_rb_q <= 12'h0;
			p1_g_q <= 12'h0;
			p2_rb_q <= 12'h0;
			p2_g_q <= 12'h0;
		end
		else if (flush || issue)
		begin
			p1_v_q <= 1'b0;
			p2_v_q <= 1'b0;
		end
		else if (take && rgb)
		begin
			p2_v_q <= p1_v_q;
			p2_rb_q <= p1_rb_q;
			p2_g_q <= p1_g_q;
			p1_v_q <= 1'b1;
			p1_rb_q <= rb_al;
			p1_g_q <= in_row2;
			p1_odd_q <= col_q[0];
		end

	// ***********************************************
	// Line sequencing and output
	// ***********************************************
	logic frame_last;
	logic out_v_d, out_l_d;
	logic [23:0] out_d;
	wire sr = (mode_q == MODE_SR);
	wire line_done = take && in_last;
	assign frame_last = (line_cnt_q >= height_q - 16'h1);

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			st_q <= ST_IDLE;
		else
			case (st_q)
				ST_IDLE:
					if (issue)
						st_q <= ST_LINE;
				ST_LINE:
					if (line_done && rgb)
						st_q <= ST_FLUSH;
					else if (line_done && mode_q == MODE_BOTH && !color)
						st_q <= ST_REPLAY;
					else if (line_done)
						st_q <= ST_IDLE;
				ST_FLUSH:
					st_q <= ST_IDLE;
				ST_REPLAY:
					if (col_q == last_col_q)
						st_q <= ST_IDLE;
				default:
					st_q <= ST_IDLE;
			endcase

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			col_q <= 12'h0;
			last_col_q <= 12'h0;
		end
		else if (issue || line_done)
		begin
			col_q <= 12'h0;
			last_col_q <= col_q;
		end
		else if (take || st_q == ST_REPLAY)
			col_q <= col_q + 12'h1;

	// Super resolution takes two cycles per column: row one, then row two
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			sr_ph_q <= 1'b0;
			sr_hold_q <= 12'h0;
			in_ready <= 1'b0;
		end
		else
		begin
			sr_ph_q <= take && sr && !color;
			if (take)
				sr_hold_q <= in_row2;
			in_ready <= (issue || (st_q == ST_LINE && !line_done)) &&
				!(take && sr && !color);
		end

	always_comb
	begin
		out_v_d = 1'b0;
		out_l_d = 1'b0;
		out_d = 24'h0;
		if (rgb)
		begin
			out_v_d = p1_v_q && (take || flush);
			out_l_d = flush;
			out_d = p1_odd_q ?
				{mis_v[11:4], p1_g_q[11:4], p1_rb_q[11:4]} :
				{p1_rb_q[11:4], p1_g_q[11:4], mis_v[11:4]};
		end
		else if (sr_ph_q)
		begin
			out_v_d = 1'b1;
			out_l_d = (st_q != ST_LINE);
			out_d = {12'h0, sr_hold_q};
		end
		else if (st_q == ST_REPLAY)
		begin
			out_v_d = 1'b1;
			out_l_d = (col_q == last_col_q);
			out_d = {12'h0, line_mem[col_q]};
		end
		else if (take)
		begin
			out_v_d = 1'b1;
			out_l_d = in_last && !(sr && !color);
			out_d = {12'h0, mono_v};
		end
	end

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			out_valid <= 1'b0;
			out_last <= 1'b0;
			out_data <= 24'h0;
			out_frame_end <= 1'b0;
			line_cnt_q <= 16'h0;
		end
		else
		begin
			out_valid <= out_v_d;
			out_last <= out_v_d && out_l_d;
			out_data <= out_d;
			out_frame_end <= out_v_d && out_l_d && frame_last;
			if (out_v_d && out_l_d)
				line_cnt_q <= frame_last ? 16'h0 : line_cnt_q + 16'h1;
		end

	// ***********************************************
	// Checks
	// ***********************************************
	a_trig_needs_acq: assert property (@(posedge clk) disable iff (!resetn)
		line_sync_trigger |-> $past(acq))
		else $error("Line trigger without acquisition");
	a_trig_starts_line: assert property (@(posedge clk) disable iff (!resetn)
		line_sync_trigger |-> st_q == ST_LINE ##0 $past(st_q) == ST_IDLE)
		else $error("Trigger issued while busy");
	a_scale_range: assert property (@(posedge clk) disable iff (!resetn)
		scale_q <= SCALE_MAX)
		else $error("Alignment scale above 1.5");
	a_mode_legal: assert property (@(posedge clk) disable iff (!resetn)
		legal_mode(model, mode_q))
		else $error("Combine mode illegal for model");
	a_sum_sat: assert property (@(posedge clk) disable iff (!resetn)
		(take && !color && mode_q == MODE_SUM) |=>
		out_valid && out_data[11:0] == sat12($past(sum13)))
		else $error("Row sum not saturated");
	a_avg_out: assert property (@(posedge clk) disable iff (!resetn)
		(take && !color && mode_q == MODE_AVG) |=>
		out_data[11:0] == 12'(($past({1'b0, in_row1}) +
		$past({1'b0, in_row2})) >> 1))
		else $error("Row average wrong");
	a_sr_two_out: assert property (@(posedge clk) disable iff (!resetn)
		(take && sr && !color) |=> !in_ready ##1 out_valid &&
		out_data[11:0] == $past(in_row2, 2))
		else $error("Second row missing in super resolution");
	a_pend_kept: assert property (@(posedge clk) disable iff (!resetn)
		(trig_event && st_q != ST_IDLE) |=> pend_q)
		else $error("Trigger lost while busy");
	a_frame_end: assert property (@(posedge clk) disable iff (!resetn)
		out_frame_end |-> out_last && $past(line_cnt_q) == height_q - 16'h1)
		else $error("Frame end at wrong line");
	a_idle_no_ready: assert property (@(posedge clk) disable iff (!resetn)
		(st_q == ST_IDLE && !$past(issue)) |-> !in_ready)
		else $error("Input accepted outside a line");
endmodule

/* pkg/dlp_pkg.sv */
// Purpose: Shared constants for the dual row line processor
// Assumes: 12-bit sensor pixels, lines of up to 4096 columns
// Notes: Register map is word aligned on AXI4-Lite
package dlp_pkg;
	// ***********************************************
	// Data path sizes
	// ***********************************************
	localparam int PIX_W = 12;
	localparam int COL_W = 12;
	localparam int LINE_MAX = 4096;
	localparam logic [11:0] PIX_MAX = 12'hfff;
	// ***********************************************
	// Register offsets
	// ***********************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_SCALE = 8'h08;
	localparam logic [7:0] OFS_RATE = 8'h0c;
	localparam logic [7:0] OFS_EXPO = 8'h10;
	localparam logic [7:0] OFS_HEIGHT = 8'h14;
	localparam logic [7:0] OFS_DEBOUNCE = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_FPS = 8'h20;
	// ***********************************************
	// Control fields
	// ***********************************************
	localparam int CTRL_ACQ = 0;
	localparam int CTRL_TRIG = 1;
	localparam int CTRL_MODEL = 2;
	localparam int CTRL_COLOR = 4;
	localparam int CTRL_RGB8 = 5;
	localparam int CTRL_ENH = 6;
	localparam logic [1:0] MODEL_2K = 2'h0;
	localparam logic [1:0] MODEL_4K = 2'h1;
	localparam logic [1:0] MODEL_8K = 2'h2;
	localparam logic [2:0] MODE_SINGLE = 3'h0;
	localparam logic [2:0] MODE_SUM = 3'h1;
	localparam logic [2:0] MODE_AVG = 3'h2;
	localparam logic [2:0] MODE_HDR = 3'h3;
	localparam logic [2:0] MODE_BOTH = 3'h4;
	localparam logic [2:0] MODE_SR = 3'h5;
	// ***********************************************
	// Reset values and timing
	// ***********************************************
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [8:0] SCALE_ONE = 9'h100;
	localparam logic [8:0] SCALE_MAX = 9'h180;
	localparam logic [31:0] RATE_RST = 32'h0000_2710;
	localparam logic [31:0] EXPO_RST = 32'h0000_0064;
	localparam logic [15:0] HEIGHT_RST = 16'h0400;
	localparam logic [15:0] DEBOUNCE_RST = 16'h0019;
	localparam logic [31:0] CLK_HZ = 32'h017d_7840;
	localparam logic [11:0] HDR_KNEE = 12'hfc0;
	localparam int HDR_SHIFT = 2;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LINE = 4'b0010,
		ST_FLUSH = 4'b0100,
		ST_REPLAY = 4'b1000
	} dlp_state_t;
endpackage

/* bench/dlp_sensor_model.sv */
// Purpose: Sensor row readout model feeding pixel pairs
// Assumes: One line of COLS columns per line trigger
// Notes: Row values are base plus column index
`timescale 1ns/1ns
module dlp_sensor_model #(
	parameter int COLS = 4
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic line_sync_trigger,
	input wire logic in_ready,
	input wire logic [11:0] base1,
	input wire logic [11:0] base2,
	output logic in_valid,
	output logic [11:0] in_row1,
	output logic [11:0] in_row2,
	output logic in_last
);
	// *************************
	// Column stepping
	// *************************
	logic [11:0] col_q;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			in_valid <= 1'b0;
			in_last <= 1'b0;
			in_row1 <= 12'h000;
			in_row2 <= 12'h000;
			col_q <= 12'h000;
		end
		else if (line_sync_trigger && !in_valid)
		begin
			in_valid <= 1'b1;
			in_row1 <= base1;
			in_row2 <= base2;
			in_last <= (COLS == 1);
			col_q <= 12'h001;
		end
		else if (in_valid && in_ready && in_last)
		begin
			in_valid <= 1'b0;
			in_last <= 1'b0;
			// Released lines flip so stale data cannot pass
			in_row1 <= ~in_row1;
			in_row2 <= ~in_row2;
		end
		else if (in_valid && in_ready)
		begin
			in_row1 <= base1 + col_q;
			in_row2 <= base2 + col_q;
			in_last <= (col_q == 12'(COLS - 1));
			col_q <= col_q + 12'h001;
		end
	end
endmodule

/* bench/dlp_line_proc_bench.sv */
// Purpose: Self-checking bench for the dual row line processor
// Assumes: Sensor model feeds four columns per line
// Notes: Free-run lines come at most every 2500 cycles
`timescale 1ns/1ns
`define CHK(n, e, g) \
	checks++; \
	if ((g) !== (e)) \
	begin \
		fails++; \
		$display("wrong value %s exp %h got %h", n, e, g); \
	end
module dlp_line_proc_bench;
	import dlp_pkg::*;
	localparam logic [11:0] B1 = 12'h7fe;
	localparam logic [11:0] B2 = 12'h800;
	logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, ext_trig;
	logic awready, wready, bvalid, arready, rvalid, trig;
	logic in_valid, in_last, in_ready, out_valid, out_last, fend;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [11:0] row1, row2;
	logic [23:0] out_data;
	logic [23:0] got_d[$];
	logic got_l[$];
	int fails, checks, trig_cnt, fe_cnt;
	dlp_line_proc DUT (.clk(clk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_trig_in(ext_trig), .line_sync_trigger(trig),
		.in_valid(in_valid), .in_row1(row1), .in_row2(row2),
		.in_last(in_last), .in_ready(in_ready), .out_valid(out_valid),
		.out_data(out_data), .out_last(out_last), .out_frame_end(fend));
	dlp_sensor_model #(.COLS(4)) sensor (.clk(clk), .resetn(resetn),
		.line_sync_trigger(trig), .in_ready(in_ready), .base1(B1),
		.base2(B2), .in_valid(in_valid), .in_row1(row1), .in_row2(row2),
		.in_last(in_last));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (trig)
			trig_cnt++;
		if (fend)
			fe_cnt++;
		if (out_valid)
		begin
			got_d.push_back(out_data);
			got_l.push_back(out_last);
		end
	end
	// *************************
	// Bus tasks
	// *************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 100 && !bvalid; i++)
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		`CHK("write answer", 1'b1, bvalid)
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 100 && !rvalid; i++)
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end
		`CHK("read answer", 1'b1, rvalid)
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic run_line(input logic [31:0] ctrl, input int n);
		got_d.delete();
		got_l.delete();
		wr(OFS_CTRL, ctrl);
		for (int i = 0; i < 8000 && got_d.size() < n; i++)
			@(posedge clk);
		`CHK("line out", 1'b1, got_d.size() >= n)
		wr(OFS_CTRL, 32'h0);
		repeat (20) @(posedge clk);
	endtask
	// *************************
	// Scenarios
	// *************************
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rd(OFS_SCALE, d, r);
		`CHK("scale", 32'h100, d)
		rd(OFS_MODE, d, r);
		`CHK("mode", 32'h0, d)
		wr(OFS_MODE, 32'h4);
		rd(OFS_MODE, d, r);
		`CHK("mode 2k", 32'h0, d)
		wr(OFS_SCALE, 32'h1ff);
		rd(OFS_SCALE, d, r);
		`CHK("scale max", 32'h180, d)
		wr(OFS_SCALE, 32'h0);
		rd(OFS_SCALE, d, r);
		`CHK("scale zero", 32'h0, d)
		rd(8'h40, d, r);
		`CHK("unmapped", 2'h2, r)
		wr(OFS_RATE, 32'd1000);
		wr(OFS_HEIGHT, 32'd10);
		// A write landing mid-division needs two full 33-cycle passes
		repeat (80) @(posedge clk);
		rd(OFS_FPS, d, r);
		`CHK("fps", 32'd100, d)
		wr(OFS_RATE, 32'd10000);
	endtask
	task automatic t_colour();
		wr(OFS_HEIGHT, 32'd4);
		run_line(32'h11, 4);
		for (int c = 0; c < 4; c++)
		begin
			`CHK("green", {12'h0, B2 + 12'(c)}, got_d[c])
		end
	endtask
	task automatic t_lines();
		logic [12:0] s;
		logic [11:0] x;
		int c0;
		c0 = trig_cnt;
		repeat (3000) @(posedge clk);
		`CHK("idle trig", c0, trig_cnt)
		wr(OFS_MODE, 32'h1);
		run_line(32'h1, 4);
		for (int c = 0; c < 4; c++)
		begin
			s = 13'(B1) + 13'(B2) + 13'(2 * c);
			x = s[12] ? PIX_MAX : s[11:0];
			`CHK("sum", {12'h0, x}, got_d[c])
		end
		wr(OFS_MODE, 32'h2);
		run_line(32'h1, 4);
		for (int c = 0; c < 4; c++)
		begin
			`CHK("avg", {12'h0, 12'(B1 + 12'h1 + 12'(c))}, got_d[c])
		end
		wr(OFS_CTRL, 32'h4);
		wr(OFS_MODE, 32'h3);
		run_line(32'h5, 4);
		for (int c = 0; c < 4; c++)
		begin
			`CHK("merge", {12'h0, B2 + 12'(c)}, got_d[c])
		end
		wr(OFS_CTRL, 32'h4);
		wr(OFS_MODE, 32'h4);
		run_line(32'h5, 8);
		for (int c = 0; c < 8; c++)
		begin
			x = c < 4 ? B1 + 12'(c) : B2 + 12'(c - 4);
			`CHK("both", {12'h0, x}, got_d[c])
			`CHK("both last", c % 4 == 3, got_l[c])
		end
		// Height 4: green, sum, average and merge lines close one frame
		`CHK("frame end", 1, fe_cnt)
	endtask
	task automatic t_sr();
		logic [11:0] x;
		wr(OFS_CTRL, 32'h8);
		wr(OFS_MODE, 32'h5);
		run_line(32'h9, 8);
		for (int c = 0; c < 8; c++)
		begin
			x = c % 2 ? B2 + 12'(c / 2) : B1 + 12'(c / 2);
			`CHK("super res", {12'h0, x}, got_d[c])
		end
		`CHK("super res last", 1'b1, got_l[7])
	endtask
	task automatic t_ext();
		logic [31:0] d;
		logic [1:0] r;
		int c0;
		rd(OFS_MODE, d, r);
		`CHK("mode model", 32'h0, d)
		wr(OFS_CTRL, 32'h3);
		got_d.delete();
		got_l.delete();
		c0 = trig_cnt;
		ext_trig <= 1'b1;
		repeat (10) @(posedge clk);
		ext_trig <= 1'b0;
		repeat (60) @(posedge clk);
		`CHK("glitch", c0, trig_cnt)
		ext_trig <= 1'b1;
		repeat (60) @(posedge clk);
		ext_trig <= 1'b0;
		repeat (60) @(posedge clk);
		`CHK("ext trig", c0 + 1, trig_cnt)
		`CHK("single count", 4, got_d.size())
		`CHK("single last", 1'b1, got_l[3])
		wr(OFS_CTRL, 32'h0);
	endtask
	task automatic give_verdict();
		if (fails == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		give_verdict();
	end
	initial
	begin
		resetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, ext_trig} = 6'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_colour();
		t_lines();
		t_sr();
		t_ext();
		give_verdict();
	end
endmodule
